/* inc/pdpcw_cfg.svh */
// Register indexes, field positions, reset values for the port control block
`ifndef PDPCW_CFG_SVH
`define PDPCW_CFG_SVH
`define PDPCW_IDX_PORT      10'h005
`define PDPCW_IDX_IRQCTL    10'h00b
`define PDPCW_IDX_IRQCTL_HI 10'h08b
`define PDPCW_IDX_OPTION    10'h081
`define PDPCW_IDX_DIR       10'h085
`define PDPCW_IDX_PWRCTL    10'h08e
`define PDPCW_IDX_PULLUP    10'h095
`define PDPCW_IDX_CHGEN     10'h096
`define PDPCW_RST_DIR       6'h3f
`define PDPCW_RST_PULLUP    6'h37
`define PDPCW_RST_CHGEN     6'h00
`define PDPCW_RST_PORT      6'h00
`define PDPCW_RST_OPTION    8'hff
`define PDPCW_RST_IRQCTL    7'h00
`define PDPCW_PIN_INONLY    3
`define PDPCW_BIT_GPULL     7
`define PDPCW_BIT_GIE       7
`define PDPCW_BIT_FLAG      0
`define PDPCW_BIT_WAKE      5
`define PDPCW_OSC_PINS      6'h30
`define PDPCW_PINS_MASK     6'h3f
`define PDPCW_PULL_MASK     6'h37
`endif

/* inc/pdpcw_pkg.sv */
// Types shared by the port control block
package pdpcw_pkg;
  typedef struct packed {
    logic [5:0] out;   // Output latch value per pin
    logic [5:0] oe;    // Drive enable per pin
    logic [5:0] pull;  // Weak pull-up active per pin
    logic       sink;  // Pin 0 wake current sink
  } pdpcw_pins_t;
  typedef struct packed {
    logic crystal;     // Crystal oscillator mode configured
    logic master_clear_input_en;     // Pin 3 is master clear input
  } pdpcw_cfg_t;
endpackage

/* rtl/pdpcw_port.sv */
// Six-pin port: direction, pull-ups, change detection and low-power wake
`timescale 1ns/10ps
`include "pdpcw_cfg.svh"
module pdpcw_port
  import pdpcw_pkg::*;
(
  input  wire logic        pclk,       // System clock, 40 MHz
  input  wire logic        presetn,    // Power-on reset, active low
  input  wire logic        warm_rst,   // Master clear or brownout reset
  input  wire logic        psel,       // APB select
  input  wire logic        penable,    // APB enable
  input  wire logic        pwrite,     // APB direction
  input  wire logic [11:0] paddr,      // APB byte address
  input  wire logic [31:0] pwdata,     // APB write data
  output logic      [31:0] prdata,     // APB read data
  output logic             pready,     // APB ready
  output logic             pslverr,    // APB error
  input  wire pdpcw_cfg_t  cfg,        // Configuration word
  input  wire logic [5:0]  pin_in,     // Raw pin levels
  output pdpcw_pins_t      pins,       // Pin drive controls
  output logic             wake,       // Wake from sleep request
  output logic             irq_vector  // Take interrupt vector
);

  logic [9:0]  idx;
  logic        acc;
  logic        wr;
  logic        setup;
  logic        mapped;
  logic [5:0]  sync1;
  logic [5:0]  sync2;
  logic [5:0]  sync3;
  logic [5:0]  lvl;
  logic [5:0]  cmp;
  logic [5:0]  port_out;
  logic [5:0]  dir;
  logic [5:0]  pull_en;
  logic [5:0]  chg_en;
  logic [7:0]  option;
  logic [7:1]  irqctl;
  logic        flag;
  logic        wake_en;
  logic [5:0]  osc_ones;
  logic [5:0]  dir_eff;
  logic [5:0]  mismatch;
  logic        port_acc;
  logic [31:0] next_rdata;

  assign idx      = paddr[11:2];
  assign acc      = psel & penable;
  assign wr       = acc & pwrite;
  assign setup    = psel & ~penable;
  assign osc_ones = cfg.crystal ? `PDPCW_OSC_PINS : 6'h00;
  assign port_acc = acc & (idx == `PDPCW_IDX_PORT);

  always_comb begin
    unique case (idx)
      `PDPCW_IDX_PORT, `PDPCW_IDX_IRQCTL, `PDPCW_IDX_IRQCTL_HI, `PDPCW_IDX_OPTION,
      `PDPCW_IDX_DIR, `PDPCW_IDX_PWRCTL, `PDPCW_IDX_PULLUP, `PDPCW_IDX_CHGEN:
        mapped = 1'b1;
      default:
        mapped = 1'b0;
    endcase
  end

  // No wait states; unmapped addresses answer with an error
  assign pready  = 1'b1;
  assign pslverr = acc & ~mapped;

  // Three-stage sampler; a level counts once stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1 <= 6'h00;
      sync2 <= 6'h00;
      sync3 <= 6'h00;
    end else begin
      sync1 <= pin_in;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lvl <= 6'h00;
    end else begin
      for (int i = 0; i < 6; i++) begin
        if (sync2[i] == sync3[i]) begin
          lvl[i] <= sync3[i];
        end
      end
    end
  end

  // Compare latch: only power-on reset touches it, warm resets leave it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp <= 6'h00;
    end else if (port_acc) begin
      cmp <= lvl;
    end
  end

  // Output data latch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_out <= `PDPCW_RST_PORT;
    end else if (warm_rst) begin
      port_out <= `PDPCW_RST_PORT;
    end else if (wr && idx == `PDPCW_IDX_PORT) begin
      port_out <= pwdata[5:0];
    end
  end

  // Configuration registers; unimplemented bits are never stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir     <= `PDPCW_RST_DIR;
      pull_en <= `PDPCW_RST_PULLUP;
      chg_en  <= `PDPCW_RST_CHGEN;
      option  <= `PDPCW_RST_OPTION;
      wake_en <= 1'b0;
    end else if (warm_rst) begin
      dir     <= `PDPCW_RST_DIR;
      pull_en <= `PDPCW_RST_PULLUP;
      chg_en  <= `PDPCW_RST_CHGEN;
      option  <= `PDPCW_RST_OPTION;
      wake_en <= 1'b0;
    end else if (wr) begin
      unique case (idx)
        `PDPCW_IDX_DIR:    dir     <= pwdata[5:0] | (6'h01 << `PDPCW_PIN_INONLY);
        `PDPCW_IDX_PULLUP: pull_en <= pwdata[5:0] & `PDPCW_PULL_MASK;
        `PDPCW_IDX_CHGEN:  chg_en  <= pwdata[5:0];
        `PDPCW_IDX_OPTION: option  <= pwdata[7:0];
        `PDPCW_IDX_PWRCTL: wake_en <= pwdata[`PDPCW_BIT_WAKE];
        default: ;
      endcase
    end
  end

  // Interrupt control bits other than the flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irqctl <= `PDPCW_RST_IRQCTL;
    end else if (warm_rst) begin
      irqctl <= `PDPCW_RST_IRQCTL;
    end else if (wr && (idx == `PDPCW_IDX_IRQCTL || idx == `PDPCW_IDX_IRQCTL_HI)) begin
      irqctl <= pwdata[7:1];
    end
  end

  // A change in the same cycle as a port access is compared against the
  // latch from before the refresh and still sets the flag; the original part may absorb it
  assign mismatch = chg_en & (lvl ^ cmp);

  // Set beats clear, so a clear cannot last while a mismatch remains
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag <= 1'b0;
    end else if (|mismatch) begin
      flag <= 1'b1;
    end else if (warm_rst) begin
      flag <= 1'b0;
    end else if (wr && (idx == `PDPCW_IDX_IRQCTL || idx == `PDPCW_IDX_IRQCTL_HI)
                 && !pwdata[`PDPCW_BIT_FLAG]) begin
      flag <= 1'b0;
    end
  end

  // Oscillator pins are never driven in crystal modes
  assign dir_eff = dir | osc_ones;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins <= '0;
    end else begin
      pins.out  <= port_out;
      pins.oe   <= ~dir_eff & `PDPCW_PINS_MASK;
      for (int i = 0; i < 6; i++) begin
        if (i == `PDPCW_PIN_INONLY) begin
          pins.pull[i] <= cfg.master_clear_input_en;
        end else begin
          pins.pull[i] <= pull_en[i] & ~option[`PDPCW_BIT_GPULL] & dir_eff[i];
        end
      end
      pins.sink <= wake_en;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake       <= 1'b0;
      irq_vector <= 1'b0;
    end else begin
      wake       <= flag;
      irq_vector <= flag & irqctl[`PDPCW_BIT_GIE];
    end
  end

  always_comb begin
    next_rdata = 32'h0000_0000;
    unique case (idx)
      `PDPCW_IDX_PORT:   next_rdata[5:0] = lvl;
      `PDPCW_IDX_DIR:    next_rdata[5:0] = dir | osc_ones;
      `PDPCW_IDX_PULLUP: next_rdata[5:0] = pull_en | osc_ones;
      `PDPCW_IDX_CHGEN:  next_rdata[5:0] = chg_en | osc_ones;
      `PDPCW_IDX_OPTION: next_rdata[7:0] = option;
      `PDPCW_IDX_PWRCTL: next_rdata[`PDPCW_BIT_WAKE] = wake_en;
      `PDPCW_IDX_IRQCTL, `PDPCW_IDX_IRQCTL_HI:
        next_rdata[7:0] = {irqctl, flag};
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  // Read data settles in the setup cycle and holds through the access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      prdata <= next_rdata;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic rd_cfg;
  logic rd_dir;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_cfg <= 1'b0;
      rd_dir <= 1'b0;
    end else begin
      rd_cfg <= setup && !pwrite && (idx == `PDPCW_IDX_DIR
                || idx == `PDPCW_IDX_PULLUP || idx == `PDPCW_IDX_CHGEN);
      rd_dir <= setup && !pwrite && idx == `PDPCW_IDX_DIR;
    end
  end

  sequence dir_write_low0;
    wr && idx == `PDPCW_IDX_DIR && !pwdata[0] && !warm_rst;
  endsequence

  sequence port_touch;
    port_acc && !$changed(lvl);
  endsequence

  sequence wake_arm;
    wr && idx == `PDPCW_IDX_PWRCTL && pwdata[`PDPCW_BIT_WAKE] && !warm_rst;
  endsequence

  dir_drive_a: assert property (dir_write_low0 |=> ##1 pins.oe[0])
    else $error("pin 0 not driven after direction cleared");

  in_only_a: assert property (rd_dir |-> prdata[`PDPCW_PIN_INONLY] && !pins.oe[3])
    else $error("pin 3 direction not input");

  osc_read_a: assert property (rd_cfg && cfg.crystal |-> prdata[5:4] == 2'b11)
    else $error("oscillator pin bits not read as one");

  high_zero_a: assert property (rd_cfg |-> prdata[7:6] == 2'b00)
    else $error("unimplemented bits read nonzero");

  pull_out_a: assert property ((pins.pull & pins.oe & 6'h37) == 6'h00)
    else $error("pull-up active on output pin");

  pull_global_a: assert property ($past(option[`PDPCW_BIT_GPULL]) |->
    (pins.pull & `PDPCW_PULL_MASK) == 6'h00)
    else $error("pull-up active while globally disabled");

  // Pins are still in reset on the first edge after release
  master_clear_input_pull_a: assert property ($past(presetn) |-> pins.pull[3] == $past(cfg.master_clear_input_en))
    else $error("pin 3 pull-up wrong");

  change_set_a: assert property (|mismatch |=> flag ##1 wake)
    else $error("mismatch did not set flag and wake");

  latch_load_a: assert property (port_touch |=> cmp == $past(lvl))
    else $error("compare latch not refreshed");

  clear_lost_a: assert property (|mismatch && wr && idx == `PDPCW_IDX_IRQCTL |=> flag)
    else $error("clear won over a live mismatch");

  warm_keep_a: assert property (warm_rst && !port_acc |=> $stable(cmp))
    else $error("compare latch lost on warm reset");

  gie_gate_a: assert property (!irqctl[`PDPCW_BIT_GIE] |=> !irq_vector)
    else $error("vector without global enable");

  sink_on_a: assert property (wake_arm |=> ##1 pins.sink)
    else $error("wake sink not enabled");

  sync_lvl_a: assert property ($changed(lvl) |->
    ($past(sync2 ^ sync3) & (lvl ^ $past(lvl))) == 6'h00)
    else $error("level moved without agreement");

  flag_hold_a: assert property (flag && !(wr && !pwdata[0]) && !warm_rst |=> flag)
    else $error("flag dropped without a clearing write");

  pwr_clear_a: assert property ($rose(presetn) |-> chg_en == 6'h00)
    else $error("change enables not cleared at power-on");

endmodule

/* dv/pdpcw_pin_model.sv */
// Behavioural pins with an RC wake capacitor on pin 0
`timescale 1ns/10ps
module pdpcw_pin_model
  import pdpcw_pkg::*;
#(
  parameter int CAP_CYC = 40
)
(
  input  wire logic        pclk,   // System clock
  input  wire pdpcw_pins_t pins,   // Device drive controls
  input  wire logic [5:0]  ext,    // External drivers
  output logic      [5:0]  pin_in  // Resolved pin levels
);
  int cap_cnt = 0;

  // Capacitor charges only while pin 0 drives high
  always_ff @(posedge pclk) begin
    if (pins.oe[0])
      cap_cnt <= pins.out[0] ? CAP_CYC : 0;
    else if (pins.sink && cap_cnt > 0)
      cap_cnt <= cap_cnt - 1;
  end

  always_comb begin
    for (int i = 0; i < 6; i++)
      pin_in[i] = pins.oe[i] ? pins.out[i] : (pins.pull[i] | ext[i]);
    // Charged capacitor holds pin 0 high until sunk away
    if (!pins.oe[0] && cap_cnt != 0)
      pin_in[0] = 1'b1;
  end
endmodule

/* dv/tb_top.sv */
// Self-checking bench for the six-pin port control block
`timescale 1ns/10ps
`include "pdpcw_cfg.svh"
module tb_top
  import pdpcw_pkg::*;
;
  localparam logic [11:0] A_PORT = {`PDPCW_IDX_PORT, 2'b00};
  localparam logic [11:0] A_IRQ  = {`PDPCW_IDX_IRQCTL, 2'b00};
  localparam logic [11:0] A_OPT  = {`PDPCW_IDX_OPTION, 2'b00};
  localparam logic [11:0] A_DIR  = {`PDPCW_IDX_DIR, 2'b00};
  localparam logic [11:0] A_PWR  = {`PDPCW_IDX_PWRCTL, 2'b00};
  localparam logic [11:0] A_PUL  = {`PDPCW_IDX_PULLUP, 2'b00};
  localparam logic [11:0] A_CHG  = {`PDPCW_IDX_CHGEN, 2'b00};
  localparam logic [11:0] A_BAD  = 12'h3fc;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        warm_rst = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] v;
  logic        pready;
  logic        pslverr;
  logic        wake;
  logic        irq_vector;
  pdpcw_cfg_t  cfg = 2'b01;
  pdpcw_pins_t pins;
  logic [5:0]  ext = 6'h00;
  logic [5:0]  pin_in;
  logic [32:0] exp_q[$];
  logic [32:0] note;
  int          error_cnt = 0;
  int          samples_checked = 0;

  always #12.5 pclk = ~pclk;

  pdpcw_port uut (.pclk(pclk), .presetn(presetn), .warm_rst(warm_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cfg(cfg), .pin_in(pin_in), .pins(pins),
    .wake(wake), .irq_vector(irq_vector));
  pdpcw_pin_model pads (.pclk(pclk), .pins(pins), .ext(ext), .pin_in(pin_in));

  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Idle cycle after each transfer keeps one assignment per time step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50) begin
      n++;
      @(posedge pclk);
    end
    if (n == 50) begin
      error_cnt++;
      $display("MISMATCH t=%0t pready=%h exp=%h", $time, pready, 1'b1);
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask

  task automatic wait_wake(input logic e, input int n);
    repeat (n) begin
      @(negedge pclk);
      if (wake === e)
        break;
    end
    chk(33'(wake), 33'(e));
    @(posedge pclk);
  endtask

  // Read results are judged at the access edge, in order of issue
  always @(posedge pclk) begin
    if (psel && penable && !pwrite && pready === 1'b1) begin
      note = exp_q.pop_front();
      chk({pslverr, prdata}, note);
    end
  end

  initial begin
    #500000;
    error_cnt++;
    tally_and_finish();
  end

  initial begin
    v = $urandom(67140);
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(A_DIR, 33'h3f);
    rd(A_PUL, 33'h37);
    rd(A_CHG, 33'h00);
    rd(A_BAD, 33'h100000000);
    chk(33'(pins.pull), 33'h08);
    for (int i = 0; i < 4; i++) begin
      v = $urandom();
      wr(A_DIR, v);
      rd(A_DIR, 33'(v[5:0] | 6'h08));
      wr(A_PUL, v);
      rd(A_PUL, 33'(v[5:0] & 6'h37));
      wr(A_CHG, v);
      rd(A_CHG, 33'(v[5:0]));
    end
    wr(A_OPT, 32'h7f);
    wr(A_PUL, 32'h37);
    wr(A_DIR, 32'h3f);
    repeat (3) @(posedge pclk);
    chk(33'(pins.pull), 33'h3f);
    wr(A_DIR, 32'h30);
    wr(A_PORT, 32'h15);
    repeat (6) @(posedge pclk);
    chk(33'(pins.oe), 33'h07);
    chk(33'(pins.out), 33'h15);
    chk(33'(pins.pull), 33'h38);
    rd(A_PORT, 33'h3d);
    wr(A_OPT, 32'hff);
    wr(A_PUL, 32'h00);
    wr(A_DIR, 32'h3f);
    repeat (6) @(posedge pclk);
    rd(A_PORT, 33'h09);
    wr(A_CHG, 32'h3b);
    wr(A_IRQ, 32'h00);
    ext <= 6'h04;
    repeat (10) @(posedge pclk);
    chk(33'(wake), 33'h0);
    wr(A_IRQ, 32'h80);
    ext <= 6'h06;
    wait_wake(1'b1, 20);
    chk(33'(irq_vector), 33'h1);
    wr(A_IRQ, 32'h80);
    rd(A_IRQ, 33'h81);
    rd(A_PORT, 33'h0f);
    wr(A_IRQ, 32'h00);
    rd(A_IRQ, 33'h00);
    ext <= 6'h04;
    wait_wake(1'b1, 20);
    chk(33'(irq_vector), 33'h0);
    wr(A_CHG, 32'h00);
    wr(A_IRQ, 32'h00);
    wait_wake(1'b0, 10);
    warm_rst <= 1'b1;
    @(posedge pclk);
    warm_rst <= 1'b0;
    @(posedge pclk);
    wr(A_CHG, 32'h02);
    wait_wake(1'b1, 20);
    rd(A_DIR, 33'h3f);
    rd(A_PORT, 33'h0d);
    wr(A_IRQ, 32'h00);
    wr(A_CHG, 32'h00);
    wr(A_PORT, 32'h01);
    wr(A_DIR, 32'h3e);
    wr(A_PWR, 32'h20);
    repeat (3) @(posedge pclk);
    chk(33'(pins.sink), 33'h1);
    wr(A_CHG, 32'h01);
    wr(A_DIR, 32'h3f);
    rd(A_PORT, 33'h0d);
    wr(A_IRQ, 32'h80);
    wait_wake(1'b1, 200);
    chk(33'(irq_vector), 33'h1);
    cfg <= 2'b11;
    wr(A_DIR, 32'h00);
    wr(A_PUL, 32'h00);
    wr(A_CHG, 32'h00);
    rd(A_DIR, 33'h38);
    rd(A_PUL, 33'h30);
    rd(A_CHG, 33'h30);
    chk(33'(pins.oe), 33'h07);
    tally_and_finish();
  end
endmodule
